// file: src/fwps_top.sv
// Write-protect, status byte and instruction gating of a serial flash.
// Assumes an SPI host in mode 0 or 3 on SPI_SCK, and an array engine on
// CLK_SYS that takes ARRAY_START and answers with ARRAY_DONE.
`timescale 1ns/1ns
module fwps_top
#(
	parameter int PUW_CYCLES = fwps_pkg::PUW_CYCLES,
	parameter int DENSITY_MBIT = 4
)
(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic SPI_SCK,
	input wire logic CS_N,
	input wire logic DI,
	input wire logic WP_N,
	input wire logic [4:0] NV_BITS,
	input wire logic ARRAY_DONE,
	output logic DO,
	output logic DO_OE,
	output logic ARRAY_START,
	output logic [2:0] ARRAY_KIND,
	output logic [23:0] ARRAY_ADDR,
	output logic [4:0] PROTECT_CFG
);

	// Number of 64KB blocks in the array for this density
	localparam logic [3:0] BLK_TOTAL = (DENSITY_MBIT == 4) ? 4'h8 :
		(DENSITY_MBIT == 2) ? 4'h4 : 4'h2;
	localparam logic [3:0] BLK_MASK = BLK_TOTAL - 4'h1;

	// Protected size in 64KB blocks for a size code
	function automatic logic [3:0] fwps_span(input logic [2:0] bp);
		logic [3:0] n;
		n = 4'h0;
		if (DENSITY_MBIT == 4)
		begin
			// Top size bit set protects everything
			if (bp[2])
				n = 4'h8; // R18
			else if (bp[1:0] != 2'h0)
				n = 4'h1 << (bp[1:0] - 2'h1); // R18
		end
		else if (DENSITY_MBIT == 2)
		begin
			// Top size bit is a don't-care here
			if (bp[1:0] == 2'h3)
				n = 4'h4; // R19
			else
				n = {2'h0, bp[1:0]}; // R19
		end
		else
		begin
			// Middle bit alone already means the whole array
			if (bp[1])
				n = 4'h2; // R20
			else
				n = {3'h0, bp[0]}; // R20
		end
		return n;
	endfunction

	// True when an address falls in the protected range
	function automatic logic fwps_hit(input logic [23:0] a,
		input logic [3:0] cfg);
		logic [3:0] blk;
		logic [3:0] n;
		blk = {1'b0, a[18:16]} & BLK_MASK;
		n = fwps_span(cfg[2:0]);
		// Select bit: zero grows from the top, one from the bottom
		if (cfg[3])
			return blk < n; // R13
		else
			return blk >= (BLK_TOTAL - n); // R13
	endfunction

	// Link side: frame capture on the serial clock

	logic live_r; // Cleared by the frame's own chip select
	logic [5:0] cnt_r; // Bits clocked in this frame
	logic [7:0] sh_r; // Input shifter
	logic [7:0] op_r; // Instruction byte
	logic [23:0] addr_r; // Address bytes
	logic [7:0] dat_r; // First data byte, for status writes
	logic [9:0] st_s1_r; // Status crossing, first stage
	logic [9:0] st_s2_r; // Status crossing, second stage
	logic do_r; // Serial output bit
	logic do_oe_r; // Serial output drive
	logic [5:0] cnt_nxt;
	logic [7:0] sh_nxt;
	wire byte_done;
	wire [7:0] st_byte;
	wire [2:0] rd_idx;
	wire rd_act;
	wire [9:0] st_w; // Status word from the system side, crossed per bit

	// Counter wraps inside its top byte so long reads keep cycling
	assign cnt_nxt = !live_r ? 6'h01 :
		(cnt_r == 6'h3f) ? 6'h38 : cnt_r + 6'h01;
	assign sh_nxt = live_r ? {sh_r[6:0], DI} : {7'h00, DI};
	assign byte_done = (cnt_nxt[2:0] == 3'h0);

	// Frame-live flag; chip select high ends the frame at once
	always_ff @(posedge SPI_SCK or posedge CS_N)
	begin
		if (CS_N)
			live_r <= 1'b0;
		else
			live_r <= 1'b1;
	end

	// Count and shift; held after the frame for the system side
	always_ff @(posedge SPI_SCK)
	begin
		cnt_r <= cnt_nxt;
		sh_r <= sh_nxt;
	end

	// Byte capture on each byte boundary up to the end of the address
	always_ff @(posedge SPI_SCK)
	begin
		if (byte_done && cnt_nxt == fwps_pkg::LEN_OP)
			op_r <= sh_nxt;
		else if (byte_done && cnt_nxt <= fwps_pkg::LEN_ADDR)
			addr_r <= {addr_r[15:0], sh_nxt};
		// Status data byte also lands in the address shifter; harmless
		if (byte_done && cnt_nxt == fwps_pkg::LEN_WSR)
			dat_r <= sh_nxt;
	end

	// Status word brought over bit by bit; each bit is its own flag
	always_ff @(posedge SPI_SCK)
	begin
		st_s1_r <= st_w;
		st_s2_r <= st_s1_r;
	end

	// Status read is served even while busy, never in power-down or reset
	assign rd_act = st_s2_r[9] & ~st_s2_r[8] & // R1 R7 R9
		(op_r == fwps_pkg::OP_RDSR) & (cnt_r >= fwps_pkg::LEN_OP);
	assign st_byte = st_s2_r[7:0];
	assign rd_idx = 3'h7 - cnt_r[2:0];

	// Output shifts on the falling edge, most significant bit first
	always_ff @(negedge SPI_SCK or posedge CS_N)
	begin
		if (CS_N)
		begin
			do_r <= 1'b0;
			do_oe_r <= 1'b0;
		end
		else
		begin
			do_r <= rd_act & st_byte[rd_idx];
			do_oe_r <= rd_act;
		end
	end

	assign DO = do_r;
	assign DO_OE = do_oe_r;

	// System side: crossing in, state and decisions

	logic cs_s1_r; // Chip select synchroniser
	logic cs_s2_r;
	logic cs_s3_r; // Edge history, reads the second stage only
	logic wp_s1_r; // Write-protect pin synchroniser
	logic wp_s2_r;
	logic [4:0] nv_s1_r; // Stored bits synchroniser
	logic [4:0] nv_s2_r;
	logic [15:0] puw_cnt_r; // Power-up write delay countdown
	logic [7:0] tmr_r; // Status write timer
	logic en_r; // Out of supply-low reset
	logic wel_r; // Write enable latch
	logic busy_r; // Busy flag
	logic pd_r; // Power-down
	logic [4:0] prot_r; // {lock, select, size2..0}
	logic start_r;
	logic [2:0] kind_r;
	logic [23:0] aaddr_r;
	fwps_pkg::fwps_phase_t phase_r;
	fwps_pkg::fwps_phase_t phase_nxt;
	logic [7:0] tmr_nxt;
	logic wel_nxt;
	logic busy_nxt;
	logic pd_nxt;
	logic [4:0] prot_nxt;
	logic start_nxt;
	logic [2:0] kind_nxt;
	logic [23:0] aaddr_nxt;
	wire fend;
	wire aligned;
	wire puw_done;
	wire lock_blk;
	wire hit;
	wire any_prot;
	wire take;
	wire wr_ok;
	wire is_wren;
	wire is_wrdi;
	wire is_wsr;
	wire is_pp;
	wire is_ers;
	wire is_ce;
	wire is_pd;
	wire is_rel;
	wire [2:0] ers_kind;

	// Status word: reserved bit forced low, select bit at S5
	assign st_w = {en_r, pd_r, prot_r[4], 1'b0, prot_r[3], // R15 R23
		prot_r[2:0], wel_r, busy_r}; // R5 R8 R10 R16

	// Frame end seen once chip select is high and the link clock still
	assign fend = cs_s2_r & ~cs_s3_r;
	assign aligned = (cnt_r[2:0] == 3'h0);
	assign puw_done = (puw_cnt_r == 16'h0000);
	// Lock only bites with the pin held low
	assign lock_blk = prot_r[4] & ~wp_s2_r; // R16 R17
	assign hit = fwps_hit(addr_r, prot_r[3:0]);
	assign any_prot = (fwps_span(prot_r[2:0]) != 4'h0);

	// Frames only count outside reset, idle and awake
	assign take = fend & en_r & (phase_r == fwps_pkg::PH_IDLE) & // R1 R9
		~pd_r; // R7
	assign wr_ok = take & aligned & wel_r & puw_done; // R2 R4 R22
	assign is_wren = take & puw_done & // R2
		(op_r == fwps_pkg::OP_WREN) & (cnt_r >= fwps_pkg::LEN_OP);
	assign is_wrdi = take & (op_r == fwps_pkg::OP_WRDI) &
		(cnt_r >= fwps_pkg::LEN_OP);
	assign is_wsr = wr_ok & ~lock_blk & // R12 R14 R17
		(op_r == fwps_pkg::OP_WRSR) & (cnt_r >= fwps_pkg::LEN_WSR);
	assign is_pp = wr_ok & ~hit & // R21
		(op_r == fwps_pkg::OP_PP) & (cnt_r >= fwps_pkg::LEN_PP);
	assign is_ers = wr_ok & ~hit & (cnt_r >= fwps_pkg::LEN_ADDR) & // R21
		((op_r == fwps_pkg::OP_SE) | (op_r == fwps_pkg::OP_BE32) |
		(op_r == fwps_pkg::OP_BE64));
	// Chip erase would touch any protected block, so any protection stops it
	assign is_ce = wr_ok & ~any_prot & (cnt_r >= fwps_pkg::LEN_OP) & // R21
		((op_r == fwps_pkg::OP_CE1) | (op_r == fwps_pkg::OP_CE2));
	assign is_pd = take & (op_r == fwps_pkg::OP_PD) &
		(cnt_r >= fwps_pkg::LEN_OP);
	// Release is the one instruction heard in power-down
	assign is_rel = fend & en_r & pd_r & // R7
		(op_r == fwps_pkg::OP_REL) & (cnt_r >= fwps_pkg::LEN_OP);
	assign ers_kind = (op_r == fwps_pkg::OP_SE) ? fwps_pkg::KIND_SE :
		(op_r == fwps_pkg::OP_BE32) ? fwps_pkg::KIND_BE32 :
		fwps_pkg::KIND_BE64;

	// Pin synchronisers; they run through reset so straps are ready
	always_ff @(posedge CLK_SYS)
	begin
		cs_s1_r <= CS_N;
		cs_s2_r <= cs_s1_r;
		wp_s1_r <= WP_N;
		wp_s2_r <= wp_s1_r;
		nv_s1_r <= NV_BITS;
		nv_s2_r <= nv_s1_r;
	end

	// Edge history of chip select; reset high so no stale end is seen
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
			cs_s3_r <= 1'b1;
		else
			cs_s3_r <= cs_s2_r;
	end

	// Power-up write delay restarts with every supply-low reset
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
			puw_cnt_r <= 16'(PUW_CYCLES); // R2
		else if (!puw_done)
			puw_cnt_r <= puw_cnt_r - 16'h0001;
	end

	// Next-state decisions for latch, busy phase and stored bits
	always_comb
	begin
		phase_nxt = phase_r;
		tmr_nxt = tmr_r;
		wel_nxt = wel_r;
		busy_nxt = busy_r;
		pd_nxt = pd_r;
		prot_nxt = prot_r;
		start_nxt = 1'b0;
		kind_nxt = kind_r;
		aaddr_nxt = aaddr_r;
		unique case (phase_r)
			fwps_pkg::PH_IDLE:
			begin
				if (is_wren)
					wel_nxt = 1'b1; // R5
				else if (is_wrdi)
					wel_nxt = 1'b0; // R6
				else if (is_wsr)
				begin
					// New bits take effect now; busy covers the write time
					prot_nxt = {dat_r[fwps_pkg::ST_LOCK], // R10 R16
						dat_r[fwps_pkg::ST_TB], // R13 R23
						dat_r[fwps_pkg::ST_SIZE0 +: 3]}; // R10
					busy_nxt = 1'b1; // R8
					tmr_nxt = 8'(fwps_pkg::WSR_CYCLES);
					phase_nxt = fwps_pkg::PH_STWR;
				end
				else if (is_pp || is_ers || is_ce)
				begin
					// Hand the job to the array engine
					busy_nxt = 1'b1; // R8
					start_nxt = 1'b1;
					kind_nxt = is_pp ? fwps_pkg::KIND_PP :
						is_ce ? fwps_pkg::KIND_CE : ers_kind;
					aaddr_nxt = is_ce ? 24'h000000 : addr_r;
					phase_nxt = fwps_pkg::PH_ARRAY;
				end
				else if (is_pd)
					pd_nxt = 1'b1; // R7
				else if (is_rel)
					pd_nxt = 1'b0; // R7
			end
			fwps_pkg::PH_ARRAY:
			begin
				// Latch drops only when the engine reports completion
				if (ARRAY_DONE)
				begin
					busy_nxt = 1'b0; // R8
					wel_nxt = 1'b0; // R6
					phase_nxt = fwps_pkg::PH_IDLE;
				end
			end
			fwps_pkg::PH_STWR:
			begin
				// Fixed status write time
				if (tmr_r == 8'h01)
				begin
					busy_nxt = 1'b0; // R8
					wel_nxt = 1'b0; // R6
					phase_nxt = fwps_pkg::PH_IDLE;
				end
				tmr_nxt = tmr_r - 8'h01;
			end
			default:
			begin
				// Unused code falls back to idle
				phase_nxt = fwps_pkg::PH_IDLE;
				busy_nxt = 1'b0;
			end
		endcase
	end

	// Volatile state; supply-low reset leaves the device write-disabled
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			en_r <= 1'b0; // R1
			wel_r <= 1'b0; // R3 R6
			busy_r <= 1'b0;
			pd_r <= 1'b0;
			phase_r <= fwps_pkg::PH_IDLE;
			tmr_r <= 8'h00;
		end
		else
		begin
			en_r <= 1'b1;
			wel_r <= wel_nxt;
			busy_r <= busy_nxt;
			pd_r <= pd_nxt;
			phase_r <= phase_nxt;
			tmr_r <= tmr_nxt;
		end
	end

	// Stored bits reload from the synchronised store during reset
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
			prot_r <= nv_s2_r; // R11
		else
			prot_r <= prot_nxt;
	end

	// Engine request: one-cycle start, kind and address held with it
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			start_r <= 1'b0;
			kind_r <= fwps_pkg::KIND_PP;
			aaddr_r <= 24'h000000;
		end
		else
		begin
			start_r <= start_nxt;
			kind_r <= kind_nxt;
			aaddr_r <= aaddr_nxt;
		end
	end

	assign ARRAY_START = start_r;
	assign ARRAY_KIND = kind_r;
	assign ARRAY_ADDR = aaddr_r;
	// Stored bits out to the non-volatile store
	assign PROTECT_CFG = prot_r;

endmodule

// file: inc/fwps_pkg.sv
// Constants shared by the flash write-protect and status block.
// Assumes a 25 MHz system clock and an SPI host on its own serial clock.
// Notes on behaviour
// R1: Supply-low reset disables all, recognises nothing.
// R2: Write-class instructions rejected during power-up delay.
// R3: Write enable latch is zero after power-up.
// R4: Program, erase, status write need latch set.
// R5: Latch is read-only bit S1, set by enable.
// R6: Latch cleared by disable and completed writes.
// R7: Power-down ignores all but release instruction.
// R8: Busy bit S0 high during program/erase/status write.
// R9: While busy, only status read is served.
// R10: Protect size bits at S4..S2, status-write only.
// R11: Protect size bits factory value zero.
// R12: Lock and low pin keep size bits.
// R13: Select bit: zero top, one bottom.
// R14: Lock and low pin keep select bit.
// R15: Reserved bit S6 always reads zero.
// R16: Lock bit S7, factory zero, pin ignored.
// R17: Lock set: pin low rejects status writes.
// R18: Four-megabit protect code mapping.
// R19: Two-megabit mapping, top size bit ignored.
// R20: One-megabit mapping, middle bit protects all.
// R21: Writes into protected range are refused.
// R22: Writes not ending on byte boundary dropped.
// R23: Select bit sits at status position S5.
package fwps_pkg;
	// Status byte positions
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;
	localparam int ST_SIZE0 = 2;
	localparam int ST_TB = 5;
	localparam int ST_RSVD = 6;
	localparam int ST_LOCK = 7;
	// Non-volatile bits {lock, select, size2..0}, factory value
	localparam logic [4:0] NV_FACTORY = 5'h00;
	// Instruction codes
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_SE = 8'h20;
	localparam logic [7:0] OP_BE32 = 8'h52;
	localparam logic [7:0] OP_BE64 = 8'hd8;
	localparam logic [7:0] OP_CE1 = 8'hc7;
	localparam logic [7:0] OP_CE2 = 8'h60;
	localparam logic [7:0] OP_PD = 8'hb9;
	localparam logic [7:0] OP_REL = 8'hab;
	// Least frame lengths in bits
	localparam logic [5:0] LEN_OP = 6'h08;
	localparam logic [5:0] LEN_WSR = 6'h10;
	localparam logic [5:0] LEN_ADDR = 6'h20;
	localparam logic [5:0] LEN_PP = 6'h28;
	// Array engine job kinds
	localparam logic [2:0] KIND_PP = 3'h0;
	localparam logic [2:0] KIND_SE = 3'h1;
	localparam logic [2:0] KIND_BE32 = 3'h2;
	localparam logic [2:0] KIND_BE64 = 3'h3;
	localparam logic [2:0] KIND_CE = 3'h4;
	// Timing
	localparam int CLK_MHZ = 25;
	localparam int PUW_TIME_US = 1000;
	localparam int PUW_CYCLES = PUW_TIME_US * CLK_MHZ;
	localparam int WSR_TIME_US = 10;
	localparam int WSR_CYCLES = WSR_TIME_US * CLK_MHZ;
	// Busy phases
	typedef enum logic [1:0] {PH_IDLE, PH_ARRAY, PH_STWR} fwps_phase_t;
endpackage

// file: tb/fwps_assertions.sv
// Port checks for the flash write-protect block, bound into its top.
// Assumes a 4-megabit array map; other densities need their own map.
`timescale 1ns/1ns
module fwps_chk
#(
	parameter int PUW_CYCLES = 20,
	parameter int DENSITY_MBIT = 4
)
(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic CS_N,
	input wire logic WP_N,
	input wire logic ARRAY_DONE,
	input wire logic DO_OE,
	input wire logic ARRAY_START,
	input wire logic [2:0] ARRAY_KIND,
	input wire logic [23:0] ARRAY_ADDR,
	input wire logic [4:0] PROTECT_CFG
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	// Cycles since reset release, saturating
	int cnt_r;
	// Engine holds a job
	logic busy_r;
	// Protected size in bytes, and job inside it
	logic [19:0] size;
	logic hit;
	assign size = PROTECT_CFG[2] ? 20'h80000 : (PROTECT_CFG[1:0] == 2'h0) ?
		20'h0 : 20'h10000 << (PROTECT_CFG[1:0] - 2'h1);
	assign hit = (ARRAY_KIND == 3'h4) ? (size != 20'h0) : PROTECT_CFG[3] ?
		({1'b0, ARRAY_ADDR[18:0]} < size) :
		({1'b0, ARRAY_ADDR[18:0]} >= 20'h80000 - size);
	// Counter restarts at every reset
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
			cnt_r <= 0;
		else if (cnt_r < PUW_CYCLES)
			cnt_r <= cnt_r + 1;
	end
	// Set by a start, cleared by the engine's answer
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
			busy_r <= 1'b0;
		else if (ARRAY_START)
			busy_r <= 1'b1;
		else if (ARRAY_DONE)
			busy_r <= 1'b0;
	end
	rst_quiet_a: assert property (disable iff (1'b0)
		!RST_N |=> !ARRAY_START) else $error("job started in reset");
	puw_delay_a: assert property (
		(ARRAY_START || $changed(PROTECT_CFG)) |-> cnt_r >= PUW_CYCLES)
		else $error("write before power-up delay");
	one_job_a: assert property (ARRAY_START |-> !busy_r)
		else $error("job started while busy");
	prot_range_a: assert property (ARRAY_START |-> !hit)
		else $error("job in protected range");
	lock_hold_a: assert property (
		(PROTECT_CFG[4] && !WP_N) [*6] |=> $stable(PROTECT_CFG))
		else $error("locked status changed");
	job_hold_a: assert property (!ARRAY_START |->
		$stable(ARRAY_KIND) && $stable(ARRAY_ADDR)) else $error("job moved");
	frame_end_a: assert property (ARRAY_START |-> CS_N && $past(CS_N, 2))
		else $error("job without closed frame");
	oe_idle_a: assert property (CS_N [*2] |-> !DO_OE)
		else $error("output driven while deselected");
	cover property (ARRAY_START);
	cover property ($changed(PROTECT_CFG));
	cover property ($fell(DO_OE));
endmodule
bind fwps_top fwps_chk #(.PUW_CYCLES(PUW_CYCLES), .DENSITY_MBIT(DENSITY_MBIT))
	chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CS_N(CS_N), .WP_N(WP_N),
	.ARRAY_DONE(ARRAY_DONE), .DO_OE(DO_OE), .ARRAY_START(ARRAY_START),
	.ARRAY_KIND(ARRAY_KIND), .ARRAY_ADDR(ARRAY_ADDR),
	.PROTECT_CFG(PROTECT_CFG));

// file: tb/fwps_host.sv
// Behavioural SPI host: mode 0 frames, MSB first, 6 ns serial clock.
// Assumes the device shifts status out on the falling serial edge.
`timescale 1ns/1ns
module fwps_host
(
	input wire logic do_i,
	output logic sck,
	output logic cs_n,
	output logic di
);
	// Clock parked low, deselected
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		di = 1'b0;
	end
	// Frame of n bits from the top of b; last 8 bits seen land in rd
	task automatic frame(input logic [47:0] b, input int n,
		output logic [7:0] rd);
		int i;
		rd = 8'h00;
		cs_n = 1'b0;
		for (i = 0; i < n; i++)
		begin
			di = b[47 - i];
			#3 sck = 1'b1;
			rd = {rd[6:0], do_i};
			#3 sck = 1'b0;
		end
		#3 cs_n = 1'b1;
		// Released line shows a changed level, not the last bit
		di = ~di;
		// Gap of five system cycles
		#200;
	endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the flash write-protect block.
// Assumes the host model and the bound checker beside it.
`timescale 1ns/1ns
module testbench;
	logic clk_sys;
	logic rst_n = 1'b0;
	logic wp_n = 1'b1;
	logic done = 1'b0;
	logic sck, cs_n, di, dout, oe, start, p;
	logic [2:0] kind, kd;
	logic [23:0] addr, a;
	logic [4:0] cfg, c;
	logic [7:0] rd;
	int k;
	integer seed = 32'hb12e010f;
	int n_mismatch = 0;
	int comparisons = 0;
	// Jobs the engine should see, oldest first
	logic [31:0] exp_q[$];
	logic [7:0] op_t[6] = '{8'h02, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
	int len_t[6] = '{40, 32, 32, 32, 8, 8};
	fwps_top #(.PUW_CYCLES(20), .DENSITY_MBIT(4)) DUT
	(
		.CLK_SYS(clk_sys), .RST_N(rst_n), .SPI_SCK(sck), .CS_N(cs_n),
		.DI(di), .WP_N(wp_n), .NV_BITS(5'h00), .ARRAY_DONE(done),
		.DO(dout), .DO_OE(oe), .ARRAY_START(start), .ARRAY_KIND(kind),
		.ARRAY_ADDR(addr), .PROTECT_CFG(cfg)
	);
	fwps_host host (.do_i(dout), .sck(sck), .cs_n(cs_n), .di(di));
	// System clock, 40 ns
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Status byte as it should read back
	function automatic logic [7:0] st(input logic [4:0] v, input logic w);
		return {v[4], 1'b0, v[3:0], w, 1'b0};
	endfunction
	// Job refused by the 4-megabit protect map
	function automatic logic prot(input logic [4:0] v, input logic [23:0] j,
		input logic [2:0] q);
		logic [19:0] sz;
		sz = v[2] ? 20'h80000 : (v[1:0] == 2'h0) ? 20'h0 :
			20'h10000 << (v[1:0] - 2'h1);
		if (q == 3'h4)
			return sz != 20'h0;
		return v[3] ? ({1'b0, j[18:0]} < sz) :
			({1'b0, j[18:0]} >= 20'h80000 - sz);
	endfunction
	task automatic op(input logic [47:0] b, input int n);
		host.frame(b, n, rd);
	endtask
	task automatic read_st(input logic [7:0] e);
		op({8'h05, 40'h0}, 16);
		check({24'h0, rd}, {24'h0, e});
	endtask
	// Poll busy, bounded
	task automatic wait_idle();
		int i;
		for (i = 0; i < 80; i++)
		begin
			op({8'h05, 40'h0}, 16);
			if (rd[0] === 1'b0)
				return;
		end
		n_mismatch++;
		complete_run();
	endtask
	// Enable, write status, enable again while busy, then read back
	task automatic wr_status(input logic [4:0] v, input logic [7:0] e);
		op({8'h06, 40'h0}, 8);
		op({8'h01, v[4], 1'b1, v[3:0], 2'b11, 32'h0}, 16);
		op({8'h06, 40'h0}, 8);
		wait_idle();
		read_st(e);
		check({27'h0, cfg}, {27'h0, e[7], e[5:2]});
	endtask
	// Engine: compare each job, answer after a random delay
	initial
	forever
	begin
		@(posedge clk_sys);
		#1;
		if (start === 1'b1)
		begin
			if (exp_q.size() == 0)
				check(32'hffffffff, 32'h0);
			else
				check({5'h0, kind, addr}, exp_q.pop_front());
			repeat ((seed & 7) + 1) @(posedge clk_sys);
			seed = $random(seed);
			#1 done = 1'b1;
			@(posedge clk_sys);
			#1 done = 1'b0;
		end
	end
	// Hang guard
	initial
	begin
		#2000000;
		n_mismatch++;
		complete_run();
	end
	initial
	begin
		#1 op({8'h06, 40'h0}, 8);
		repeat (3) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		op({8'h06, 40'h0}, 8);
		read_st(8'h00);
		repeat (25) @(posedge clk_sys);
		#1 op({8'h06, 40'h0}, 8);
		read_st(8'h02);
		op({8'h04, 40'h0}, 8);
		read_st(8'h00);
		op({8'h02, 24'h001000, 16'h0}, 40);
		read_st(8'h00);
		op({8'h06, 40'h0}, 8);
		op({8'h02, 24'h001000, 16'h0}, 44);
		read_st(8'h02);
		op({8'h04, 40'h0}, 8);
		for (k = 0; k < 12; k++)
		begin
			c = 5'($random(seed)) & 5'h0f;
			@(posedge clk_sys);
			#1 wp_n = 1'($random(seed));
			wr_status(c, st(c, 1'b0));
			a = 24'($random(seed)) & 24'h07ffff;
			kd = (k % 6 > 4) ? 3'h4 : 3'(k % 6);
			p = prot(c, a, kd);
			if (!p)
				exp_q.push_back({5'h0, kd, (kd == 3'h4) ? 24'h0 : a});
			op({8'h06, 40'h0}, 8);
			op({op_t[k % 6], a, 16'h5a5a}, len_t[k % 6]);
			wait_idle();
			read_st(st(c, p));
			op({8'h04, 40'h0}, 8);
		end
		@(posedge clk_sys);
		#1 wp_n = 1'b1;
		wr_status(5'h17, st(5'h17, 1'b0));
		@(posedge clk_sys);
		#1 wp_n = 1'b0;
		wr_status(5'h08, st(5'h17, 1'b1));
		@(posedge clk_sys);
		#1 wp_n = 1'b1;
		wr_status(5'h00, st(5'h00, 1'b0));
		op({8'hb9, 40'h0}, 8);
		// Asleep: status read gets no answer and the output stays off
		read_st(8'h00);
		check({31'h0, oe}, 32'h0);
		op({8'h06, 40'h0}, 8);
		op({8'hab, 40'h0}, 32);
		read_st(8'h00);
		// Mid-run supply-low reset with the latch set and a frame inside
		op({8'h06, 40'h0}, 8);
		@(posedge clk_sys);
		#1 rst_n = 1'b0;
		op({8'h06, 40'h0}, 8);
		repeat (3) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		repeat (25) @(posedge clk_sys);
		#1 read_st(8'h00);
		check(32'(exp_q.size()), 32'h0);
		complete_run();
	end
endmodule
